/* File: verilog/drc_controller.sv */
// Host-side controller that drives the multiplexed-address DRAM pins
`timescale 1ns/1ps
`default_nettype none
module drc_controller
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User request
  input wire logic reqValid,
  input wire drc_pkg::drc_req_t req,
  output logic reqReady,
  output logic rdValid,
  output logic rdData,
  // Memory pins
  output var drc_pkg::drc_pins_t pins,
  input wire logic dout
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  drc_pkg::drc_state_t state_q, state_d;
  logic [drc_pkg::CNT_W-1:0] tmr_q, tmr_d;
  logic [drc_pkg::CNT_W-1:0] refTmr_q;
  logic [drc_pkg::HALF_W-1:0] refRow_q;
  logic refPend_q, initDone_q, isRef_q, isWr_q, isRd_q;
  logic [drc_pkg::HALF_W-1:0] colAddr_q;
  logic reqReady_q, rdValid_q, rdData_q;
  drc_pkg::drc_pins_t pins_q, pins_d;
  logic [drc_pkg::CNT_W-1:0] rasLowCnt_q, casLowCnt_q, rasHighCnt_q;

  function automatic logic [drc_pkg::CNT_W-1:0] cyc(input int n);
    cyc = drc_pkg::CNT_W'(n - 1);
  endfunction

  function automatic logic [drc_pkg::CNT_W-1:0] satInc(input logic [drc_pkg::CNT_W-1:0] v);
    satInc = (v == '1) ? v : v + 1'b1;
  endfunction

  wire tmrDone = (tmr_q == '0);
  wire refTick = (refTmr_q == '0);
  // Refresh (and first init cycle) takes priority over user traffic
  wire doRef = refPend_q || !initDone_q; // [R5] [R6]
  wire start = (state_q == drc_pkg::ST_IDLE) && (doRef || reqValid);
  wire takeReq = start && !doRef;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    tmr_d = tmrDone ? tmr_q : tmr_q - 1'b1;
    pins_d = pins_q;
    case (state_q)
      drc_pkg::ST_IDLE:
      begin
        if (start)
        begin
          // Row half driven first, chip select high for refresh
          pins_d.muxAddrPins = doRef ? refRow_q : req.addr[5:0]; // [R2] [R3] [R9] [R13]
          pins_d.csN = doRef ? 1'b1 : 1'b0; // [R11]
          pins_d.weN = doRef ? 1'b1 : !req.write; // [R10]
          pins_d.din = req.data;
          state_d = drc_pkg::ST_ROW;
        end
      end
      drc_pkg::ST_ROW:
      begin
        pins_d.rasN = 1'b0; // [R3] [R9]
        tmr_d = cyc(drc_pkg::RCL_CYC);
        state_d = drc_pkg::ST_COL;
      end
      drc_pkg::ST_COL:
      begin
        // Row address held past the strobe for the row hold time
        if (tmrDone)
        begin
          pins_d.muxAddrPins = colAddr_q; // [R3] [R13]
          pins_d.casN = 1'b0; // [R3] [R11]
          tmr_d = cyc(drc_pkg::RASW_CYC - drc_pkg::RCL_CYC);
          state_d = drc_pkg::ST_HOLD;
        end
      end
      drc_pkg::ST_HOLD:
      begin
        // Both strobes kept low until their minimum widths elapse
        if (tmrDone)
        begin
          pins_d.rasN = 1'b1; // [R12] [R13]
          pins_d.casN = 1'b1;
          pins_d.weN = 1'b1;
          tmr_d = cyc(drc_pkg::RP_CYC);
          state_d = drc_pkg::ST_PRE;
        end
      end
      drc_pkg::ST_PRE:
      begin
        if (tmrDone)
        begin
          state_d = drc_pkg::ST_IDLE; // [R12]
        end
      end
      default:
      begin
        state_d = drc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= drc_pkg::ST_IDLE;
      tmr_q <= '0;
      pins_q <= '{rasN: 1'b1, casN: 1'b1, csN: 1'b1, weN: 1'b1, muxAddrPins: '0, din: 1'b0};
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      pins_q <= pins_d;
    end
  end

  // ------------------------------------------------------------------
  // Request bookkeeping and refresh scheduling
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      refTmr_q <= cyc(drc_pkg::REF_ROW_CYC);
      refRow_q <= '0;
      refPend_q <= 1'b0;
      initDone_q <= 1'b0;
      isRef_q <= 1'b0;
      isWr_q <= 1'b0;
      isRd_q <= 1'b0;
      colAddr_q <= '0;
      reqReady_q <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q <= 1'b0;
    end
    else
    begin
      refTmr_q <= refTick ? cyc(drc_pkg::REF_ROW_CYC) : refTmr_q - 1'b1;
      // A tick in the same cycle as a refresh start keeps the request
      if (refTick)
      begin
        refPend_q <= 1'b1; // [R5]
      end
      else if (start && doRef)
      begin
        refPend_q <= 1'b0;
      end
      if (start)
      begin
        isRef_q <= doRef;
        isWr_q <= !doRef && req.write;
        isRd_q <= !doRef && !req.write;
        colAddr_q <= doRef ? '0 : req.addr[11:6];
      end
      if (start && doRef)
      begin
        refRow_q <= refRow_q + 1'b1; // [R5]
        initDone_q <= 1'b1; // [R6]
      end
      reqReady_q <= takeReq;
      // Output bit is valid once the strobes complete their widths
      rdValid_q <= (state_q == drc_pkg::ST_HOLD) && tmrDone && isRd_q; // [R7]
      if ((state_q == drc_pkg::ST_HOLD) && tmrDone && isRd_q)
      begin
        rdData_q <= dout; // [R1]
      end
    end
  end

  assign reqReady = reqReady_q;
  assign rdValid = rdValid_q;
  assign rdData = rdData_q;
  assign pins = pins_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Strobe level counters; they saturate so long idle spans cannot wrap
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rasLowCnt_q <= '0;
      casLowCnt_q <= '0;
      rasHighCnt_q <= '1;
    end
    else
    begin
      rasLowCnt_q <= pins_q.rasN ? '0 : satInc(rasLowCnt_q);
      casLowCnt_q <= pins_q.casN ? '0 : satInc(casLowCnt_q);
      rasHighCnt_q <= pins_q.rasN ? satInc(rasHighCnt_q) : '0;
    end
  end

  sequence rowPhase_s;
    !pins.rasN && pins.casN;
  endsequence

  casAfterRas_a: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    $fell(pins.casN) |-> $past(!pins.rasN, drc_pkg::RCL_CYC))
    else $error("Column strobe fell without row strobe lead");
  rasWidth_a: assert property (@(posedge clk) disable iff (!resetn) // [R12]
    $rose(pins.rasN) |-> (rasLowCnt_q >= drc_pkg::RASW_CYC))
    else $error("Row strobe pulse too short");
  casWidth_a: assert property (@(posedge clk) disable iff (!resetn) // [R12]
    $rose(pins.casN) |-> (casLowCnt_q >= drc_pkg::CAS_CYC))
    else $error("Column strobe pulse too short");
  precharge_a: assert property (@(posedge clk) disable iff (!resetn) // [R12]
    $fell(pins.rasN) |-> (rasHighCnt_q >= drc_pkg::RP_CYC))
    else $error("Precharge too short");
  rowAddrHold_a: assert property (@(posedge clk) disable iff (!resetn) // [R13]
    $fell(pins.rasN) |=> $stable(pins.muxAddrPins) throughout rowPhase_s [*8])
    else $error("Row address changed during row hold");
  refSelect_a: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    (start && doRef) |=> pins.csN && pins.weN)
    else $error("Refresh cycle not deselected");
  refServed_a: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    $rose(refPend_q) |-> ##[1:100] !refPend_q)
    else $error("Refresh request not served");
  initFirst_a: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    reqReady |-> initDone_q)
    else $error("Access before initialization cycle");
  writeEarly_a: assert property (@(posedge clk) disable iff (!resetn) // [R10]
    $fell(pins.casN) && isWr_q |-> !pins.weN)
    else $error("Write strobe not low before column strobe");
endmodule
`default_nettype wire

/* File: verilog/drc_pkg.sv */
// Package of constants and types for the strobe-driven DRAM controller
// Function
// [R1] Device holds 4096 one-bit words
// [R2] Twelve-bit address sent as two six-bit halves
// [R3] Row half by row strobe, column by column
// [R4] Device latches address, select and data in
// [R5] Refresh all 64 rows every 2 ms
// [R6] Initialization cycle before first normal access
// [R7] Device output three-state, latched into next cycle
// [R8] Device floats output after deselecting cycles
// [R9] Cycle starts with row address, row strobe falling
// [R10] Write strobe low before column strobe means write
// [R11] Chip select sampled at column strobe
// [R12] Honour strobe pulse widths and precharge
// [R13] Sequence row, strobe, column, strobe, release
`default_nettype none
package drc_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int HALF_W = 6;
  localparam int ROWS = 64;
  // ----------------------------------------------------------------
  // Timing (slowest grade, ns) and derived cycle counts at 125 MHz
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int T_RAS_NS = 300;
  localparam int T_CAS_NS = 165;
  localparam int T_RCL_NS = 80;
  localparam int T_RAH_NS = 80;
  localparam int T_RP_NS = 125;
  localparam int T_REF_MS = 2;
  localparam int RCL_CYC = (T_RCL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RASW_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  // Interval per row so all rows are covered within the period, rounded down
  localparam int REF_PERIOD_CYC = T_REF_MS * 1000000 / CLK_NS;
  localparam int REF_ROW_CYC = REF_PERIOD_CYC / ROWS;
  localparam int CNT_W = 12;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW  = 3'b001,
    ST_COL  = 3'b010,
    ST_HOLD = 3'b011,
    ST_PRE  = 3'b100
  } drc_state_t;
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic data;
  } drc_req_t;
  typedef struct packed {
    logic rasN;
    logic casN;
    logic csN;
    logic weN;
    logic [HALF_W-1:0] muxAddrPins;
    logic din;
  } drc_pins_t;
endpackage
`default_nettype wire

/* File: test/drc_mem_model.sv */
// Behavioural model of the 4096 x 1 strobe-driven memory device
`timescale 1ns/1ps
`default_nettype none
module drc_mem_model
(
  // Memory pins
  input wire drc_pkg::drc_pins_t pins,
  output logic dout,
  // Counts for the bench
  output int faults,
  output int refreshes
);
  logic mem [4096];
  logic [5:0] rowQ;
  logic rowOpen = 1'b0;
  logic casLow = 1'b0;
  logic casSeen = 1'b0;
  logic initDone = 1'b0;
  logic outQ = 1'b0;
  logic outOn = 1'b0;
  realtime rasFall = 0.0;
  realtime casFall = 0.0;
  realtime rasRise = -1000.0;
  initial faults = 0;
  initial refreshes = 0;
  // Floating output shows the inverse of the last bit, never a stale copy
  assign dout = outOn ? outQ : ~outQ;
  always @(negedge pins.rasN)
  begin
    if ($realtime - rasRise < 125.0) faults++;
    rowQ = pins.muxAddrPins;
    rowOpen = 1'b1;
    rasFall = $realtime;
  end
  always @(negedge pins.casN)
  begin
    casFall = $realtime;
    casLow = 1'b1;
    casSeen = rowOpen;
    if (!rowOpen) outOn = 1'b0;
    else if (pins.csN)
    begin
      outOn = 1'b0;
      refreshes++;
    end
    else
    begin
      if (!initDone) faults++;
      if (!pins.weN) mem[{pins.muxAddrPins, rowQ}] = pins.din;
      outQ = pins.weN ? mem[{pins.muxAddrPins, rowQ}] : pins.din;
      outOn = 1'b1;
    end
  end
  // Edges out of the unknown power-up level are not pulse ends
  always @(posedge pins.casN)
  begin
    if (casLow && $realtime - casFall < 165.0) faults++;
    casLow = 1'b0;
  end
  always @(posedge pins.rasN)
  begin
    if (rowOpen)
    begin
      if ($realtime - rasFall < 300.0) faults++;
      if (casSeen) initDone = 1'b1;
      rasRise = $realtime;
    end
    casSeen = 1'b0;
    rowOpen = 1'b0;
  end
endmodule
`default_nettype wire

/* File: test/test_dram_4k_x1_strobe_interface.sv */
// Self-checking bench for the strobe-driven memory controller
`timescale 1ns/1ps
`default_nettype none
module test_dram_4k_x1_strobe_interface;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reqValid = 1'b0;
  drc_pkg::drc_req_t req = '0;
  logic reqReady, rdValid, rdData, dout;
  drc_pkg::drc_pins_t pins;
  int faults, refreshes;
  int num_errors = 0;
  int cmp_count = 0;
  int refBefore = 0;
  int refMem [4096];
  logic [11:0] adr [$];
  always #4 clk = ~clk;
  drc_controller i_drc_controller (.clk(clk), .resetn(resetn), .reqValid(reqValid),
    .req(req), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData), .pins(pins),
    .dout(dout));
  drc_mem_model i_drc_mem_model (.pins(pins), .dout(dout), .faults(faults),
    .refreshes(refreshes));
  task check(input logic ok);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Request held until accepted, then released; reads compared with the bench's refMem record
  task access(input logic wr, input logic [11:0] a, input logic d);
    int n;
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{write: wr, addr: a, data: d};
    n = 0;
    do begin @(posedge clk); #1; n++; end while (reqReady !== 1'b1 && n < 9000);
    check(n < 9000);
    @(posedge clk);
    reqValid <= 1'b0;
    if (wr)
      refMem[a] = d;
    else
    begin
      n = 0;
      do begin @(posedge clk); #1; n++; end while (rdValid !== 1'b1 && n < 200);
      check(n < 200 && rdData === refMem[a][0]);
    end
  endtask
  initial
  begin
    void'($urandom(32'h689D));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    adr = '{12'h000, 12'hFFF, 12'h03F, 12'hFC0};
    repeat (20) adr.push_back(12'($urandom));
    foreach (adr[i]) access(1'b1, adr[i], 1'($urandom));
    foreach (adr[i]) access(1'b0, adr[i], 1'b0);
    access(1'b1, adr[0], ~refMem[adr[0]][0]);
    access(1'b0, adr[0], 1'b0);
    // Idle long enough for the row refresh timer to fire; the init cycle is not counted
    refBefore = refreshes;
    repeat (4000) @(posedge clk);
    check(refreshes > refBefore);
    access(1'b0, adr[1], 1'b0);
    check(faults == 0);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
